// *** irq_dispatch_pkg.sv ***
// constants and types for the multi-vector interrupt dispatch block
// Operation
// - thirteen one-word vector locations in a contiguous area, one per source
// - on entry push program counter to return stack, load source vector
// - accumulator and sixteen working registers saved by hardware, restored on return
// - vectors ascend: wake, ext0, ext1, timers, adc, serial, msp, uart rx, tx
// - priority follows vector order, wake highest, uart transmit lowest
// - simultaneous requests served one at a time, highest priority first
// - requests during a routine are held, no pre-emption, served by priority
// - wake goes to first vector, external zero to the next
package irq_dispatch_pkg;

  localparam int          SRC_COUNT     = 13;
  localparam int          PC_WIDTH      = 13;
  localparam int          DATA_WIDTH    = 8;
  localparam int          WORK_REGS     = 16;
  localparam int          SRC_IDX_WIDTH = 4;
  localparam int          CTX_WIDTH     = DATA_WIDTH * (WORK_REGS + 1);

  // first vector location; source n sits at base plus n
  localparam logic [PC_WIDTH-1:0] VECTOR_BASE = 13'h0008;

  // source index order is vector order
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_WAKE         = 4'h0;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_EXT_ZERO     = 4'h1;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_EXT_ONE      = 4'h2;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_TIMER_ZERO   = 4'h3;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_TC_A         = 4'h4;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_TC_B         = 4'h5;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_TC_C         = 4'h6;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_TIMER_ONE    = 4'h7;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_ADC          = 4'h8;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_SERIAL       = 4'h9;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_MASTER_SLAVE = 4'hA;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_UART_RX      = 4'hB;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_UART_TX      = 4'hC;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_ENTER   = 3'b010,
    ST_SERVICE = 3'b100
  } dispatch_state_type;

endpackage

// *** irq_context_store.sv ***
// one-entry context store for accumulator and working registers
`timescale 1ns/1ps
module irq_context_store
  import irq_dispatch_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 save_strobe,
  input  wire logic [CTX_WIDTH-1:0] save_data,
  output logic      [CTX_WIDTH-1:0] load_data
);

  logic [CTX_WIDTH-1:0] ctx_reg;

  // no nesting, so a single slot is enough
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ctx_reg <= '0;
    else if (save_strobe)
      ctx_reg <= save_data;
  end

  assign load_data = ctx_reg;

endmodule // irq_context_store

// *** irq_dispatch.sv ***
// top of the multi-vector interrupt dispatch block
`timescale 1ns/1ps
module irq_dispatch
  import irq_dispatch_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [SRC_COUNT-1:0]  irq_request,
  input  wire logic                  instr_boundary,
  input  wire logic                  return_from_interrupt,
  input  wire logic [PC_WIDTH-1:0]   current_pc,
  input  wire logic [PC_WIDTH-1:0]   stack_top_pc,
  input  wire logic [DATA_WIDTH-1:0] accumulator,
  input  wire logic [DATA_WIDTH*WORK_REGS-1:0] working_regs,
  output logic                       stack_push,
  output logic [PC_WIDTH-1:0]        stack_push_pc,
  output logic                       stack_pop,
  output logic                       pc_load,
  output logic [PC_WIDTH-1:0]        pc_load_value,
  output logic                       ctx_restore,
  output logic [DATA_WIDTH-1:0]      accumulator_restore,
  output logic [DATA_WIDTH*WORK_REGS-1:0] working_regs_restore,
  output logic                       in_service,
  output logic [SRC_COUNT-1:0]       pending,
  output logic [SRC_IDX_WIDTH-1:0]   active_source
);

  // -----------------------------------------------------------------
  // arbitration
  // -----------------------------------------------------------------

  dispatch_state_type          state_reg;
  logic [SRC_COUNT-1:0]        pending_reg;
  logic [SRC_IDX_WIDTH-1:0]    winner_next;
  logic                        any_pending;
  logic [CTX_WIDTH-1:0]        ctx_saved;
  logic                        take_irq;
  logic                        ret_accept;
  dispatch_state_type          state_next;

  // lowest index wins; index order equals vector order
  function automatic logic [SRC_IDX_WIDTH-1:0] pick_highest(input logic [SRC_COUNT-1:0] req);
    logic [SRC_IDX_WIDTH-1:0] idx;
    idx = SRC_UART_TX;
    for (int i = SRC_COUNT - 1; i >= 0; i--)
      if (req[i])
        idx = SRC_IDX_WIDTH'(i);
    return idx;
  endfunction

  // vector is base plus source index, one word each
  function automatic logic [PC_WIDTH-1:0] vector_of(input logic [SRC_IDX_WIDTH-1:0] src);
    return VECTOR_BASE + PC_WIDTH'(src);
  endfunction

  assign winner_next = pick_highest(pending_reg);
  assign any_pending = |pending_reg;
  assign take_irq    = (state_reg == ST_IDLE) && any_pending && instr_boundary;

  // -----------------------------------------------------------------
  // pending flags
  // -----------------------------------------------------------------

  // requests latched and held pending
  // new request beats the clear of the serviced bit
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pending_reg <= '0;
    else if (take_irq)
      pending_reg <= (pending_reg & ~(SRC_COUNT'(1) << winner_next)) | irq_request;
    else
      pending_reg <= pending_reg | irq_request;
  end

  // -----------------------------------------------------------------
  // sequencing
  // -----------------------------------------------------------------

  // a return counts only once the routine runs; an early one is dropped
  assign ret_accept = (state_reg == ST_SERVICE) && return_from_interrupt;

  // one routine at a time, re-arbitrate after return
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (take_irq)
          state_next = ST_ENTER;
      end
      ST_ENTER:
      begin
        state_next = ST_SERVICE;
      end
      ST_SERVICE:
      begin
        if (ret_accept)
          state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // -----------------------------------------------------------------
  // entry
  // -----------------------------------------------------------------

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stack_push    <= 1'b0;
      stack_push_pc <= '0;
      active_source <= '0;
    end
    else
    begin
      stack_push <= take_irq;
      if (take_irq)
      begin
        stack_push_pc <= current_pc;
        active_source <= winner_next;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pc_load       <= 1'b0;
      pc_load_value <= '0;
    end
    else
    begin
      pc_load <= take_irq || ret_accept;
      if (take_irq)
        pc_load_value <= vector_of(winner_next);
      else if (ret_accept)
        pc_load_value <= stack_top_pc;
    end
  end

  // -----------------------------------------------------------------
  // return
  // -----------------------------------------------------------------

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stack_pop   <= 1'b0;
      ctx_restore <= 1'b0;
    end
    else
    begin
      stack_pop   <= ret_accept;
      ctx_restore <= ret_accept;
    end
  end

  // level stays up from entry until the return is accepted
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      in_service <= 1'b0;
    else
      in_service <= (state_next != ST_IDLE);
  end

  // visible copy trails the internal flags by one cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pending <= '0;
    else
      pending <= pending_reg;
  end

  // -----------------------------------------------------------------
  // context save
  // -----------------------------------------------------------------

  irq_context_store u_ctx (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .save_strobe (take_irq),
    .save_data   ({accumulator, working_regs}),
    .load_data   (ctx_saved)
  );

  // restore values registered beside the pulse
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      accumulator_restore  <= '0;
      working_regs_restore <= '0;
    end
    else
    begin
      accumulator_restore  <= ctx_saved[CTX_WIDTH-1 -: DATA_WIDTH];
      working_regs_restore <= ctx_saved[DATA_WIDTH*WORK_REGS-1:0];
    end
  end

endmodule // irq_dispatch

// *** irq_dispatch_props.sv ***
// assertion checker for the interrupt dispatch block
`timescale 1ns/1ps
module irq_dispatch_props
  import irq_dispatch_pkg::*;
(
  input wire logic                     clk,
  input wire logic                     sys_rst,
  input wire logic                     instr_boundary,
  input wire logic                     return_from_interrupt,
  input wire logic [PC_WIDTH-1:0]      current_pc,
  input wire logic [PC_WIDTH-1:0]      stack_top_pc,
  input wire logic                     stack_push,
  input wire logic [PC_WIDTH-1:0]      stack_push_pc,
  input wire logic                     stack_pop,
  input wire logic                     pc_load,
  input wire logic [PC_WIDTH-1:0]      pc_load_value,
  input wire logic                     ctx_restore,
  input wire logic                     in_service,
  input wire logic [SRC_IDX_WIDTH-1:0] active_source
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----
  // checks
  // ----
  property p_push; stack_push |-> pc_load && in_service; endproperty
  a_push: assert property (p_push) else $error("push without entry");
  property p_vec; stack_push |-> pc_load_value == VECTOR_BASE + active_source; endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");
  property p_pc; stack_push |-> stack_push_pc == $past(current_pc); endproperty
  a_pc: assert property (p_pc) else $error("wrong saved pc");
  property p_bound; stack_push |-> $past(instr_boundary); endproperty
  a_bound: assert property (p_bound) else $error("take off boundary");
  property p_hold; in_service && !return_from_interrupt |=> !stack_push; endproperty
  a_hold: assert property (p_hold) else $error("routine pre-empted");
  property p_ret;
    in_service && return_from_interrupt |=> stack_pop && ctx_restore && !in_service;
  endproperty
  a_ret: assert property (p_ret) else $error("return not done");
  property p_rpc; stack_pop |-> pc_load && pc_load_value == $past(stack_top_pc); endproperty
  a_rpc: assert property (p_rpc) else $error("wrong return pc");
  property p_one; stack_push |=> !stack_push [*2]; endproperty
  a_one: assert property (p_one) else $error("entries too close");
  c_take: cover property (stack_push);
  c_ret: cover property (stack_pop);
  c_last: cover property (stack_push && active_source == SRC_UART_TX);
endmodule // irq_dispatch_props

// *** cpu_seq_model.sv ***
// cpu sequencer model facing the dispatch block
`timescale 1ns/1ps
module cpu_seq_model
  import irq_dispatch_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic [7:0]              isr_len,
  input  wire logic                    stack_push,
  input  wire logic [PC_WIDTH-1:0]     stack_push_pc,
  input  wire logic                    stack_pop,
  input  wire logic                    pc_load,
  input  wire logic [PC_WIDTH-1:0]     pc_load_value,
  input  wire logic                    in_service,
  output logic                         instr_boundary,
  output logic                         return_from_interrupt,
  output logic [PC_WIDTH-1:0]          current_pc,
  output logic [PC_WIDTH-1:0]          stack_top_pc,
  output logic [DATA_WIDTH-1:0]        accumulator,
  output logic [DATA_WIDTH*WORK_REGS-1:0] working_regs
);
  logic [7:0] cnt_reg;
  // boundary on even pc only, so a take must sometimes wait for it
  assign instr_boundary = !current_pc[0];
  // live context follows pc, so it differs from what was saved
  assign accumulator = current_pc[7:0];
  assign working_regs = {WORK_REGS{current_pc[7:0]}};
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) stack_top_pc <= 13'h0000;
    else if (stack_push) stack_top_pc <= stack_push_pc;
    else if (stack_pop) stack_top_pc <= ~stack_top_pc;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) current_pc <= 13'h0100;
    else if (pc_load) current_pc <= pc_load_value;
    else current_pc <= current_pc + 13'h0001;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      cnt_reg <= 8'h00;
      return_from_interrupt <= 1'b0;
    end
    else
    begin
      return_from_interrupt <= in_service && !return_from_interrupt && cnt_reg == isr_len;
      cnt_reg <= (in_service && !return_from_interrupt) ? cnt_reg + 8'h01 : 8'h00;
    end
endmodule // cpu_seq_model

// *** tb.sv ***
// self-checking bench for the interrupt dispatch block
`timescale 1ns/1ps
module tb;
  import irq_dispatch_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [SRC_COUNT-1:0] irq_request = '0;
  logic [7:0] isr_len = 8'h03;
  int errors = 0;
  int comparisons = 0;
  logic instr_boundary, return_from_interrupt, stack_push, stack_pop, pc_load;
  logic ctx_restore, in_service;
  logic [PC_WIDTH-1:0] current_pc, stack_top_pc, stack_push_pc, pc_load_value;
  logic [DATA_WIDTH-1:0] accumulator, accumulator_restore;
  logic [DATA_WIDTH*WORK_REGS-1:0] working_regs, working_regs_restore;
  logic [SRC_IDX_WIDTH-1:0] active_source;
  logic [SRC_COUNT-1:0] pending;
  irq_dispatch dut (.clk, .sys_rst, .irq_request, .instr_boundary, .return_from_interrupt,
    .current_pc, .stack_top_pc, .accumulator, .working_regs, .stack_push, .stack_push_pc,
    .stack_pop, .pc_load, .pc_load_value, .ctx_restore, .accumulator_restore,
    .working_regs_restore, .in_service, .pending, .active_source);
  cpu_seq_model cpu (.clk, .sys_rst, .isr_len, .stack_push, .stack_push_pc, .stack_pop,
    .pc_load, .pc_load_value, .in_service, .instr_boundary, .return_from_interrupt,
    .current_pc, .stack_top_pc, .accumulator, .working_regs);
  always #4 clk = ~clk;
  task automatic chk(input string what, input logic [PC_WIDTH-1:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // bounded wait for entry or return
  task automatic wait_for(input logic entry);
    int i;
    for (i = 0; i < 200; i++)
    begin
      @(negedge clk);
      if ((entry ? stack_push : stack_pop) === 1'b1) break;
    end
    if (i == 200)
    begin
      errors++;
      close_out();
    end
  endtask
  task automatic go(input int n);
    wait_for(1'b1);
    chk("vector", pc_load_value, VECTOR_BASE + PC_WIDTH'(n));
    chk("source", PC_WIDTH'(active_source), PC_WIDTH'(n));
  endtask
  task automatic done;
    wait_for(1'b0);
    chk("acc", PC_WIDTH'(accumulator_restore), PC_WIDTH'(stack_push_pc[7:0]));
    chk("regs", PC_WIDTH'(working_regs_restore == {WORK_REGS{stack_push_pc[7:0]}}), 13'h0001);
    chk("ret pc", pc_load_value, stack_push_pc);
  endtask
  task automatic pulse(input logic [SRC_COUNT-1:0] m);
    irq_request = m;
    @(negedge clk);
    irq_request = '0;
  endtask
  task automatic t_each;
    for (int n = 0; n < SRC_COUNT; n++)
    begin
      pulse(13'h0001 << n);
      go(n);
      done();
    end
  endtask
  task automatic t_sim;
    int ord[5] = '{0, 3, 6, 7, 9};
    pulse(13'h02C9);
    foreach (ord[k])
    begin
      go(ord[k]);
      done();
    end
  endtask
  // arrivals in mixed order must leave in priority order
  task automatic t_held;
    int arr[7] = '{8, 5, 3, 9, 1, 7, 11};
    int ord[8] = '{0, 1, 3, 5, 7, 8, 9, 11};
    isr_len = 8'h14;
    pulse(13'h0001);
    go(0);
    foreach (arr[k])
    begin
      irq_request = 13'h0001 << arr[k];
      @(negedge clk);
    end
    irq_request = '0;
    @(negedge clk);
    chk("pending", pending, 13'h0BAA);
    done();
    for (int k = 1; k < 8; k++)
    begin
      go(ord[k]);
      done();
    end
  endtask
  // reset in mid-service drops the routine and every held request
  task automatic t_reset;
    pulse(13'h0003);
    go(0);
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk("pending after reset", pending, 13'h0000);
    chk("service after reset", PC_WIDTH'(in_service), 13'h0000);
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    t_each();
    t_sim();
    t_held();
    t_reset();
    close_out();
  end
endmodule // tb
bind irq_dispatch irq_dispatch_props chk_u (.clk, .sys_rst, .instr_boundary,
  .return_from_interrupt, .current_pc, .stack_top_pc, .stack_push, .stack_push_pc,
  .stack_pop, .pc_load, .pc_load_value, .ctx_restore, .in_service, .active_source);
